// ### cisr_pkg.sv
// shared constants, state codes and carrier types of the clock input supervisor
package cisr_pkg;
	// register byte offsets
	localparam logic [3:0] OFF_CONTROL = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h4;
	// control field positions and reset values
	localparam int CTL_INHIBIT_BIT = 0;
	localparam int CTL_LAMP_LO = 4;
	localparam int CTL_LAMP_HI = 5;
	localparam logic CTL_INHIBIT_RST = 1'h0;
	// status field positions
	localparam int ST_CLK_GOOD_BIT = 0;
	localparam int ST_OSC_BIT = 1;
	localparam int ST_REF_BIT = 2;
	localparam int ST_LOCK_BIT = 3;
	localparam int ST_SEL_KEEP_BIT = 4;
	localparam int ST_SEL_GEN_BIT = 5;
	localparam int ST_FSM_LO = 8;
	localparam int ST_FSM_HI = 10;
	// lamp mode codes
	localparam logic [1:0] LAMP_CLK = 2'h0;
	localparam logic [1:0] LAMP_CLK_OSC = 2'h1;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	// supervision timing: window to judge activity, patience in keepalive
	localparam int CLK_PERIOD_NS = 10;
	localparam int WINDOW_NS = 640;
	localparam int KEEPALIVE_TIMEOUT_NS = 20000;
	localparam int WINDOW_CYC = (WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int KEEPALIVE_TIMEOUT_CYC = KEEPALIVE_TIMEOUT_NS / CLK_PERIOD_NS;
	// reported state codes
	localparam logic [2:0] CODE_RESET = 3'h0;
	localparam logic [2:0] CODE_START = 3'h1;
	localparam logic [2:0] CODE_KEEP = 3'h2;
	localparam logic [2:0] CODE_TIMEOUT = 3'h3;
	localparam logic [2:0] CODE_WAIT1 = 3'h4;
	localparam logic [2:0] CODE_WAIT2 = 3'h5;
	localparam logic [2:0] CODE_WAIT3 = 3'h6;
	localparam logic [2:0] CODE_GOOD = 3'h7;

	// supervision states, one-hot
	typedef enum logic [7:0] {
		ST_RESET = 8'h01,
		ST_START = 8'h02,
		ST_KEEP = 8'h04,
		ST_TIMEOUT = 8'h08,
		ST_WAIT1 = 8'h10,
		ST_WAIT2 = 8'h20,
		ST_WAIT3 = 8'h40,
		ST_GOOD = 8'h80
	} cisr_state_t;

	// generator status lines as one bundle
	typedef struct packed {
		logic lock;
		logic ref_ok;
		logic osc_ok;
	} cisr_gen_stat_t;

	// supervisor results as one bundle
	typedef struct packed {
		logic [2:0] fsm_code;
		logic sel_gen;
		logic sel_keep;
		logic clk_good;
	} cisr_sup_t;

	// state to reported code
	function automatic logic [2:0] state_code(input cisr_state_t s);
		case (s)
			ST_START: state_code = CODE_START;
			ST_KEEP: state_code = CODE_KEEP;
			ST_TIMEOUT: state_code = CODE_TIMEOUT;
			ST_WAIT1: state_code = CODE_WAIT1;
			ST_WAIT2: state_code = CODE_WAIT2;
			ST_WAIT3: state_code = CODE_WAIT3;
			ST_GOOD: state_code = CODE_GOOD;
			default: state_code = CODE_RESET;
		endcase
	endfunction
endpackage

// ### cisr_supervisor.sv
// clock supervision state machine with generator clock activity check
`timescale 1ns/1ps
`default_nettype none
module cisr_supervisor #(
	parameter int WINDOW = cisr_pkg::WINDOW_CYC,
	parameter int TIMEOUT = cisr_pkg::KEEPALIVE_TIMEOUT_CYC
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clock_en,
	input wire logic gen_clk,
	input wire logic inhibit,
	output var cisr_pkg::cisr_sup_t sup
);
	initial
	begin
		if (WINDOW < 4 || WINDOW > 65536 || TIMEOUT < WINDOW)
			$error("supervisor counts out of range");
	end

	logic gen_prev_r;
	logic seen_r;
	logic active_r;
	logic [15:0] win_r;
	logic [31:0] tmo_r;
	cisr_pkg::cisr_state_t state_r;
	cisr_pkg::cisr_state_t state_nxt;
	logic win_end;
	logic tmo_end;

	assign win_end = (win_r == 16'(WINDOW - 1));
	assign tmo_end = (tmo_r == 32'(TIMEOUT - 1));

	// activity: any edge of the generator clock inside each window
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			gen_prev_r <= 1'b0;
			seen_r <= 1'b0;
			active_r <= 1'b0;
			win_r <= 16'h0000;
		end
		else if (clock_en)
		begin
			gen_prev_r <= gen_clk;
			win_r <= win_end ? 16'h0000 : win_r + 16'h0001;
			if (win_end)
			begin
				active_r <= seen_r || (gen_clk != gen_prev_r);
				seen_r <= 1'b0;
			end
			else if (gen_clk != gen_prev_r)
				seen_r <= 1'b1;
		end
	end

	// next state
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			cisr_pkg::ST_RESET: if (!inhibit) state_nxt = cisr_pkg::ST_START;
			cisr_pkg::ST_START: state_nxt = cisr_pkg::ST_KEEP;
			cisr_pkg::ST_KEEP:
				if (inhibit)
					state_nxt = cisr_pkg::ST_RESET;
				else if (active_r)
					state_nxt = cisr_pkg::ST_TIMEOUT;
				else if (tmo_end)
					state_nxt = cisr_pkg::ST_START;
			cisr_pkg::ST_TIMEOUT: state_nxt = cisr_pkg::ST_WAIT1;
			cisr_pkg::ST_WAIT1: state_nxt = cisr_pkg::ST_WAIT2;
			cisr_pkg::ST_WAIT2: state_nxt = cisr_pkg::ST_WAIT3;
			cisr_pkg::ST_WAIT3: state_nxt = cisr_pkg::ST_GOOD;
			cisr_pkg::ST_GOOD: if (inhibit || !active_r) state_nxt = cisr_pkg::ST_RESET;
			default: state_nxt = cisr_pkg::ST_RESET;
		endcase
	end

	// state register and keepalive patience counter
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			state_r <= cisr_pkg::ST_RESET;
			tmo_r <= 32'h0000_0000;
		end
		else if (clock_en)
		begin
			state_r <= state_nxt;
			tmo_r <= (state_r == cisr_pkg::ST_KEEP) ? tmo_r + 32'h0000_0001 : 32'h0000_0000;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			sup <= '0;
		else if (clock_en)
		begin
			sup.fsm_code <= cisr_pkg::state_code(state_nxt);
			sup.sel_keep <= (state_nxt == cisr_pkg::ST_KEEP);
			sup.sel_gen <= (state_nxt == cisr_pkg::ST_WAIT3) || (state_nxt == cisr_pkg::ST_GOOD);
			sup.clk_good <= (state_nxt == cisr_pkg::ST_GOOD);
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst || !clock_en);

	sequence s_handover;
		sup.fsm_code == cisr_pkg::CODE_TIMEOUT ##1 sup.fsm_code == cisr_pkg::CODE_WAIT1
		##1 sup.fsm_code == cisr_pkg::CODE_WAIT2;
	endsequence
	property p_wait_chain;
		s_handover |-> ##1 sup.fsm_code == cisr_pkg::CODE_WAIT3 ##1 sup.fsm_code == cisr_pkg::CODE_GOOD;
	endproperty
	a_wait_chain: assert property (p_wait_chain) else $error("wait chain broken");
	property p_good_code;
		sup.clk_good |-> sup.fsm_code == cisr_pkg::CODE_GOOD && sup.sel_gen && !sup.sel_keep;
	endproperty
	a_good_code: assert property (p_good_code) else $error("good state code wrong");
	property p_keep_code;
		sup.sel_keep |-> sup.fsm_code == cisr_pkg::CODE_KEEP && !sup.sel_gen;
	endproperty
	a_keep_code: assert property (p_keep_code) else $error("keepalive code wrong");
endmodule
`default_nettype wire

// ### cisr_top.sv
// clock input supervisor: register pair, status sync, lamp and sample clock
// Contract
// - inhibit bit set blocks generator sample clock
// - lamp select field reads back, writable
// - lamp mode 00 shows clock good
// - mode 01 adds oscillator valid
// - modes 10,11 need all four conditions
// - lamp output driven active low
// - status bits 3:1 show generator lines
// - status bits 10:8 show state, reset zero
// - codes 000 reset,001 start,010 keep,011 timeout
// - codes 100 wait1, 101 wait2
// - codes 110 wait3, 111 good
// - status bit 5 is generator select
// - status bit 4 is keepalive select
// - status bit 3 is lock
// - status bit 2 is reference valid
// - status bit 1 is oscillator valid
// - status bit 0 is clock good
`timescale 1ns/1ps
`default_nettype none
module cisr_top #(
	parameter int WINDOW = cisr_pkg::WINDOW_CYC,
	parameter int TIMEOUT = cisr_pkg::KEEPALIVE_TIMEOUT_CYC
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clock_en,
	input wire logic [1:0] lamp_mode_init,
	input wire logic gen_clk,
	input wire cisr_pkg::cisr_gen_stat_t gen_stat,
	output logic sample_clk,
	output logic led_n,
	output logic clk_good,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic inhibit_r;
	logic [1:0] lamp_r;
	cisr_pkg::cisr_gen_stat_t stat_meta_r;
	cisr_pkg::cisr_gen_stat_t stat_r;
	cisr_pkg::cisr_sup_t sup;
	logic keep_clk_r;
	logic lamp_ok;
	logic wr_go;
	logic rd_go;
	logic [31:0] status_word;
	logic [31:0] control_word;

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			stat_meta_r <= '0;
			stat_r <= '0;
		end
		else if (clock_en)
		begin
			stat_meta_r <= gen_stat;
			stat_r <= stat_meta_r;
		end
	end

	cisr_supervisor #(
		.WINDOW(WINDOW),
		.TIMEOUT(TIMEOUT)
	) u_sup (
		.clock(clock),
		.sys_rst(sys_rst),
		.clock_en(clock_en),
		.gen_clk(gen_clk),
		.inhibit(inhibit_r),
		.sup(sup)
	);

	always_comb
	begin
		control_word = cisr_pkg::WORD_ZERO;
		control_word[cisr_pkg::CTL_INHIBIT_BIT] = inhibit_r;
		control_word[cisr_pkg::CTL_LAMP_HI:cisr_pkg::CTL_LAMP_LO] = lamp_r;
		status_word = cisr_pkg::WORD_ZERO;
		status_word[cisr_pkg::ST_FSM_HI:cisr_pkg::ST_FSM_LO] = sup.fsm_code;
		status_word[cisr_pkg::ST_SEL_GEN_BIT] = sup.sel_gen;
		status_word[cisr_pkg::ST_SEL_KEEP_BIT] = sup.sel_keep;
		status_word[cisr_pkg::ST_LOCK_BIT] = stat_r.lock;
		status_word[cisr_pkg::ST_REF_BIT] = stat_r.ref_ok;
		status_word[cisr_pkg::ST_OSC_BIT] = stat_r.osc_ok;
		status_word[cisr_pkg::ST_CLK_GOOD_BIT] = sup.clk_good;
	end

	// write channel takes address and data together
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign rd_go = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_arready = rd_go;

	// control register; only low byte holds fields
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			inhibit_r <= cisr_pkg::CTL_INHIBIT_RST;
			lamp_r <= lamp_mode_init;
		end
		else if (clock_en && wr_go && s_axi_awaddr == cisr_pkg::OFF_CONTROL && s_axi_wstrb[0])
		begin
			inhibit_r <= s_axi_wdata[cisr_pkg::CTL_INHIBIT_BIT];
			lamp_r <= s_axi_wdata[cisr_pkg::CTL_LAMP_HI:cisr_pkg::CTL_LAMP_LO];
		end
	end

	// write response; status is read-only and accepted silently
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= cisr_pkg::RESP_OKAY;
		end
		else if (clock_en)
		begin
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				if (s_axi_awaddr == cisr_pkg::OFF_CONTROL || s_axi_awaddr == cisr_pkg::OFF_STATUS)
					s_axi_bresp <= cisr_pkg::RESP_OKAY;
				else
					s_axi_bresp <= cisr_pkg::RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// read data path
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= cisr_pkg::WORD_ZERO;
			s_axi_rresp <= cisr_pkg::RESP_OKAY;
		end
		else if (clock_en)
		begin
			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				if (s_axi_araddr == cisr_pkg::OFF_CONTROL)
				begin
					s_axi_rdata <= control_word;
					s_axi_rresp <= cisr_pkg::RESP_OKAY;
				end
				else if (s_axi_araddr == cisr_pkg::OFF_STATUS)
				begin
					s_axi_rdata <= status_word;
					s_axi_rresp <= cisr_pkg::RESP_OKAY;
				end
				else
				begin
					s_axi_rdata <= cisr_pkg::WORD_ZERO;
					s_axi_rresp <= cisr_pkg::RESP_SLVERR;
				end
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// lamp condition by mode
	always_comb
	begin
		if (lamp_r == cisr_pkg::LAMP_CLK)
			lamp_ok = sup.clk_good;
		else if (lamp_r == cisr_pkg::LAMP_CLK_OSC)
			lamp_ok = sup.clk_good && stat_r.osc_ok;
		else
			lamp_ok = sup.clk_good && stat_r.osc_ok && stat_r.ref_ok && stat_r.lock;
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
			led_n <= 1'b1;
		else if (clock_en)
			led_n <= !lamp_ok;
	end

	// keepalive clock: half the bus clock
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			keep_clk_r <= 1'b0;
		else if (clock_en)
			keep_clk_r <= !keep_clk_r;
	end

	// sample clock source, generator path gated by inhibit
	always_ff @(posedge clock)
	begin
		if (sys_rst)
			sample_clk <= 1'b0;
		else if (clock_en)
		begin
			if (sup.sel_gen && !inhibit_r)
				sample_clk <= gen_clk;
			else if (sup.sel_keep)
				sample_clk <= keep_clk_r;
			else
				sample_clk <= 1'b0;
		end
	end

	assign clk_good = sup.clk_good;

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst || !clock_en);

	property p_inhibit_stops;
		inhibit_r && $past(inhibit_r) |-> ##[1:3] (sup.fsm_code != cisr_pkg::CODE_GOOD);
	endproperty
	a_inhibit_stops: assert property (p_inhibit_stops) else $error("inhibit ignored");
	property p_lamp_readback;
		s_axi_rvalid && $past(rd_go) && $past(s_axi_araddr) == cisr_pkg::OFF_CONTROL
			|-> s_axi_rdata[cisr_pkg::CTL_LAMP_HI:cisr_pkg::CTL_LAMP_LO] == $past(lamp_r);
	endproperty
	a_lamp_readback: assert property (p_lamp_readback) else $error("lamp readback wrong");
	property p_mode0;
		lamp_r == cisr_pkg::LAMP_CLK && $stable(lamp_r) |=> led_n == !$past(sup.clk_good);
	endproperty
	a_mode0: assert property (p_mode0) else $error("mode 00 lamp wrong");
	property p_mode1;
		lamp_r == cisr_pkg::LAMP_CLK_OSC |=> led_n == !($past(sup.clk_good) && $past(stat_r.osc_ok));
	endproperty
	a_mode1: assert property (p_mode1) else $error("mode 01 lamp wrong");
	property p_mode23;
		lamp_r[1] && $stable(lamp_r) && !led_n |-> $past(stat_r.lock) && $past(stat_r.ref_ok)
			&& $past(stat_r.osc_ok) && $past(sup.clk_good);
	endproperty
	a_mode23: assert property (p_mode23) else $error("mode 1x lamp wrong");
	property p_lamp_low;
		!led_n |-> $past(sup.clk_good);
	endproperty
	a_lamp_low: assert property (p_lamp_low) else $error("lamp lit without clock");
	property p_sync_delay;
		##2 1'b1 |-> stat_r == $past(gen_stat, 2);
	endproperty
	a_sync_delay: assert property (p_sync_delay) else $error("sync depth wrong");
	sequence s_read_status;
		rd_go && s_axi_araddr == cisr_pkg::OFF_STATUS;
	endsequence
	property p_status_reserved;
		s_read_status |=> s_axi_rdata[31:11] == 21'h0 && s_axi_rdata[7:6] == 2'h0
			&& s_axi_rdata[10:8] == $past(sup.fsm_code) && s_axi_rdata[3] == $past(stat_r.lock);
	endproperty
	a_status_reserved: assert property (p_status_reserved) else $error("status word wrong");
	property p_inhibit_sample;
		inhibit_r && !sup.sel_keep |=> !sample_clk;
	endproperty
	a_inhibit_sample: assert property (p_inhibit_sample) else $error("sample clock not held");
	property p_gen_sample;
		sup.sel_gen && !inhibit_r |=> sample_clk == $past(gen_clk);
	endproperty
	a_gen_sample: assert property (p_gen_sample) else $error("generator clock not passed");
	property p_status_bits;
		s_read_status |=> s_axi_rdata[cisr_pkg::ST_SEL_GEN_BIT] == $past(sup.sel_gen)
			&& s_axi_rdata[cisr_pkg::ST_SEL_KEEP_BIT] == $past(sup.sel_keep)
			&& s_axi_rdata[cisr_pkg::ST_CLK_GOOD_BIT] == $past(sup.clk_good)
			&& s_axi_rdata[cisr_pkg::ST_REF_BIT] == $past(stat_r.ref_ok)
			&& s_axi_rdata[cisr_pkg::ST_OSC_BIT] == $past(stat_r.osc_ok);
	endproperty
	a_status_bits: assert property (p_status_bits) else $error("status bits wrong");
endmodule
`default_nettype wire

// ### cisr_gen_model.sv
// generator model: clock that can stop, and three status levels
`timescale 1ns/1ps
`default_nettype none
module cisr_gen_model #(
	parameter int HALF_NS = 17
) (
	input wire logic run,
	input wire logic [2:0] stat_set,
	output logic gen_clk,
	output var cisr_pkg::cisr_gen_stat_t gen_stat
);
	// clock toggles only while running, rests low when stopped
	initial
	begin
		gen_clk = 1'b0;
		// half-nanosecond offset keeps generator edges off the bus clock edges
		#0.5;
		forever
		begin
			#(HALF_NS);
			gen_clk = run ? ~gen_clk : 1'b0;
		end
	end
	// status levels follow the requested pattern
	assign gen_stat = cisr_pkg::cisr_gen_stat_t'(stat_set);
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the clock input supervisor registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clock, sys_rst, run, gen_clk, sample_clk, led_n, clk_good, e, ce;
	logic [2:0] stat_set;
	logic [1:0] lamp_mode_init, bresp, rresp, resp_r;
	cisr_pkg::cisr_gen_stat_t gen_stat;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, rd_r;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	int fails, samples_checked, n;

	// bus clock, 10 ns
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	cisr_gen_model u_gen (.run(run), .stat_set(stat_set), .gen_clk(gen_clk), .gen_stat(gen_stat));

	cisr_top #(.WINDOW(8), .TIMEOUT(64)) u_dut (
		.clock(clock), .sys_rst(sys_rst), .clock_en(ce), .lamp_mode_init(lamp_mode_init),
		.gen_clk(gen_clk), .gen_stat(gen_stat), .sample_clk(sample_clk), .led_n(led_n),
		.clk_good(clk_good), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask

	// a handshake that never completes counts as a mismatch
	task automatic hung(input string what);
		if (n >= 50)
		begin
			fails++;
			$display("ERROR %0t %s hung", $time, what);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge clock);
	endtask

	// one write: hold request until taken, then accept the response
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		awaddr = a;
		wdata = d;
		wstrb = s;
		awvalid = 1'b1;
		wvalid = 1'b1;
		n = 0;
		#1;
		while (!(awready === 1'b1 && wready === 1'b1) && n < 50)
		begin
			@(negedge clock);
			n++;
		end
		hung("write request");
		@(negedge clock);
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b1;
		n = 0;
		while (bvalid !== 1'b1 && n < 50)
		begin
			@(negedge clock);
			n++;
		end
		hung("write response");
		resp_r = bresp;
		@(negedge clock);
		bready = 1'b0;
	endtask

	// one read: hold request until taken, capture data and response
	task automatic rd(input logic [3:0] a);
		araddr = a;
		arvalid = 1'b1;
		n = 0;
		#1;
		while (arready !== 1'b1 && n < 50)
		begin
			@(negedge clock);
			n++;
		end
		hung("read request");
		@(negedge clock);
		arvalid = 1'b0;
		rready = 1'b1;
		n = 0;
		while (rvalid !== 1'b1 && n < 50)
		begin
			@(negedge clock);
			n++;
		end
		hung("read data");
		rd_r = rdata;
		resp_r = rresp;
		@(negedge clock);
		rready = 1'b0;
	endtask

	// poll the status word until the state field shows a code
	task automatic wait_code(input logic [2:0] c);
		for (int k = 0; k < 40; k++)
		begin
			rd(4'h4);
			if (rd_r[10:8] === c)
				break;
		end
	endtask

	// count sample clock changes over k cycles
	task automatic toggles(input int k);
		logic v;
		n = 0;
		repeat (k)
		begin
			v = sample_clk;
			@(negedge clock);
			if (sample_clk !== v)
				n++;
		end
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// watchdog against a hung handshake
	initial
	begin
		repeat (20000) @(posedge clock);
		fails++;
		final_report();
	end

	// main sequence
	initial
	begin
		fails = 0;
		samples_checked = 0;
		sys_rst = 1'b1;
		run = 1'b0;
		ce = 1'b1;
		stat_set = 3'h5;
		lamp_mode_init = 2'h1;
		{awaddr, araddr, wstrb, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		cyc(4);
		chk({31'h0, led_n}, 32'h1, "lamp in reset");
		chk({31'h0, clk_good}, 32'h0, "good in reset");
		sys_rst = 1'b0;
		rd(4'h0);
		chk(rd_r, 32'h0000_0010, "control reset");
		chk({30'h0, resp_r}, 32'h0, "read resp");
		wait_code(cisr_pkg::CODE_KEEP);
		chk(rd_r, 32'h0000_021A, "keepalive status");
		toggles(16);
		chk({31'h0, n > 8}, 32'h1, "keepalive clock");
		$display("test reset and keepalive done");
		run = 1'b1;
		wait_code(cisr_pkg::CODE_GOOD);
		chk(rd_r, 32'h0000_072B, "good status");
		chk({31'h0, clk_good}, 32'h1, "good pin");
		toggles(16);
		chk({31'h0, n > 0}, 32'h1, "sample clock runs");
		ce = 1'b0;
		toggles(8);
		chk({n[29:0], clk_good, led_n}, 32'h2, "frozen by enable");
		ce = 1'b1;
		for (int p = 0; p < 8; p++)
		begin
			stat_set = p[2:0];
			cyc(4);
			rd(4'h4);
			chk(rd_r, 32'h0000_0721 | (p << 1), "status lines");
		end
		$display("test good clock and status done");
		for (int m = 0; m < 4; m++)
		begin
			wr(4'h0, 32'(m) << 4, 4'hF);
			rd(4'h0);
			chk(rd_r, 32'(m) << 4, "lamp readback");
			for (int p = 0; p < 8; p++)
			begin
				stat_set = p[2:0];
				cyc(6);
				e = (m == 0) ? 1'b1 : (m == 1) ? p[0] : (p == 7);
				chk({31'h0, led_n}, {31'h0, ~e}, "lamp drive");
			end
		end
		$display("test lamp modes done");
		wr(4'h0, 32'hFFFF_FFCF, 4'hF);
		rd(4'h0);
		chk(rd_r, 32'h0000_0001, "inhibit readback");
		cyc(6);
		toggles(16);
		chk({n[29:0], sample_clk, clk_good}, 32'h0, "sample clock held");
		rd(4'h4);
		chk(rd_r, 32'h0000_000E, "inhibited status");
		wr(4'h0, 32'h0000_0000, 4'h0);
		rd(4'h0);
		chk(rd_r, 32'h0000_0001, "strobe off write");
		wr(4'h4, 32'hFFFF_FFFF, 4'hF);
		chk({30'h0, resp_r}, 32'h0, "status write resp");
		rd(4'h4);
		chk(rd_r, 32'h0000_000E, "status unchanged");
		wr(4'h8, 32'hFFFF_FFFF, 4'hF);
		chk({30'h0, resp_r}, 32'h2, "unmapped write");
		rd(4'h8);
		chk({rd_r[29:0], resp_r}, 32'h2, "unmapped read");
		$display("test inhibit and access done");
		wr(4'h0, 32'h0000_0000, 4'hF);
		wait_code(cisr_pkg::CODE_GOOD);
		chk(rd_r, 32'h0000_072F, "enabled again");
		$display("test re-enable done");
		sys_rst = 1'b1;
		cyc(4);
		chk({29'h0, led_n, sample_clk, clk_good}, 32'h4, "outputs in second reset");
		sys_rst = 1'b0;
		rd(4'h4);
		chk(rd_r & 32'hFFFF_FFF1, 32'h0, "state after reset");
		rd(4'h0);
		chk(rd_r, 32'h0000_0010, "lamp mode reloaded");
		$display("test second reset done");
		final_report();
	end
endmodule
`default_nettype wire
